// File: src/fcc_regs.sv
// Fan curve configuration registers and automatic fan drive control
`timescale 1ns/100ps
module fcc_regs
#(
    parameter int STEP_PERIOD_CYCLES = fcc_pkg::STEP_PERIOD_CYCLES  // Quiet step interval
)
(
    input  wire logic        CLK,            // 25 MHz system clock
    input  wire logic        RST,            // Async reset, active high
    input  wire logic [7:0]  REG_ADDR,       // Register offset
    input  wire logic        REG_WR,         // Write strobe
    input  wire logic [7:0]  REG_WDATA,      // Write data
    output logic      [7:0]  REG_RDATA,      // Read data, one cycle after address
    input  wire logic        AUTO_MODE,      // Automatic fan control selected
    input  wire logic        OFFSET_FORMAT,  // Configuration bit 7: offset binary codes
    input  wire logic [7:0]  TEMP_TH_A,      // Thermistor a / remote diode b reading
    input  wire logic [7:0]  TEMP_TH_B,      // Thermistor b reading
    input  wire logic [7:0]  TEMP_REMOTE,    // Remote diode a reading
    input  wire logic [7:0]  TEMP_LOCAL,     // Local reading
    input  wire logic [7:0]  ON_TEMP_TH_A,   // Fan on temperature, thermistor a
    input  wire logic [7:0]  ON_TEMP_TH_B,   // Fan on temperature, thermistor b
    input  wire logic [7:0]  ON_TEMP_REMOTE, // Fan on temperature, remote
    input  wire logic [7:0]  ON_TEMP_LOCAL,  // Fan on temperature, local
    input  wire logic [7:0]  CRIT_TH_A,      // Critical limit, thermistor a
    input  wire logic [7:0]  CRIT_TH_B,      // Critical limit, thermistor b
    input  wire logic [7:0]  CRIT_REMOTE,    // Critical limit, remote
    input  wire logic [7:0]  CRIT_LOCAL,     // Critical limit, local
    input  wire logic        FAN_A_TACH,     // Fan a tach level
    input  wire logic        FAN_B_TACH,     // Fan b tach level
    input  wire logic [15:0] FAN_A_PERIOD,   // Fan a measured tach period
    input  wire logic [15:0] FAN_B_PERIOD,   // Fan b measured tach period
    output logic      [7:0]  FAN_A_DRIVE,    // Fan a drive output
    output logic      [7:0]  FAN_B_DRIVE     // Fan b drive output
);

    // ==========================================================
    // Configuration registers
    logic [7:0] critical_temp_limit_span_r,   critical_temp_limit_span_nxt;
    logic [7:0] rl_span_r,      rl_span_nxt;
    logic [7:0] critical_temp_limit_hyst_r,   critical_temp_limit_hyst_nxt;
    logic [7:0] rl_hyst_r,      rl_hyst_nxt;
    logic [7:0] startup_r [2];
    logic [7:0] startup_nxt [2];
    logic [7:0] floor_r [2];
    logic [7:0] floor_nxt [2];
    logic [7:0] ceiling_r [2];
    logic [7:0] ceiling_nxt [2];
    logic [7:0] quiet_r,        quiet_nxt;
    logic [7:0] rdata_r,        rdata_nxt;

    // Register writes land in the next-value logic
    always_comb
    begin
        critical_temp_limit_span_nxt = critical_temp_limit_span_r;
        rl_span_nxt    = rl_span_r;
        critical_temp_limit_hyst_nxt = critical_temp_limit_hyst_r;
        rl_hyst_nxt    = rl_hyst_r;
        startup_nxt    = startup_r;
        floor_nxt      = floor_r;
        ceiling_nxt    = ceiling_r;
        quiet_nxt      = quiet_r;
        if (REG_WR)
        begin
            case (REG_ADDR)
                fcc_pkg::OFF_CRITICAL_TEMP_LIMIT_SPAN: critical_temp_limit_span_nxt = REG_WDATA;
                fcc_pkg::OFF_RL_SPAN:    rl_span_nxt    = REG_WDATA;
                fcc_pkg::OFF_CRITICAL_TEMP_LIMIT_HYST: critical_temp_limit_hyst_nxt = REG_WDATA;
                fcc_pkg::OFF_RL_HYST:    rl_hyst_nxt    = REG_WDATA;
                fcc_pkg::OFF_A_STARTUP:  startup_nxt[0] = REG_WDATA;
                fcc_pkg::OFF_B_STARTUP:  startup_nxt[1] = REG_WDATA;
                fcc_pkg::OFF_A_FLOOR:    floor_nxt[0]   = REG_WDATA;
                fcc_pkg::OFF_B_FLOOR:    floor_nxt[1]   = REG_WDATA;
                fcc_pkg::OFF_A_CEILING:  ceiling_nxt[0] = REG_WDATA;
                fcc_pkg::OFF_B_CEILING:  ceiling_nxt[1] = REG_WDATA;
                fcc_pkg::OFF_QUIET_STEP: quiet_nxt      = REG_WDATA;
                default:                 quiet_nxt      = quiet_r;
            endcase
        end
    end

    // Read mux; unmapped offsets read zero
    always_comb
    begin
        case (REG_ADDR)
            fcc_pkg::OFF_CRITICAL_TEMP_LIMIT_SPAN: rdata_nxt = critical_temp_limit_span_r;
            fcc_pkg::OFF_RL_SPAN:    rdata_nxt = rl_span_r;
            fcc_pkg::OFF_CRITICAL_TEMP_LIMIT_HYST: rdata_nxt = critical_temp_limit_hyst_r;
            fcc_pkg::OFF_RL_HYST:    rdata_nxt = rl_hyst_r;
            fcc_pkg::OFF_A_STARTUP:  rdata_nxt = startup_r[0];
            fcc_pkg::OFF_B_STARTUP:  rdata_nxt = startup_r[1];
            fcc_pkg::OFF_A_FLOOR:    rdata_nxt = floor_r[0];
            fcc_pkg::OFF_B_FLOOR:    rdata_nxt = floor_r[1];
            fcc_pkg::OFF_A_CEILING:  rdata_nxt = ceiling_r[0];
            fcc_pkg::OFF_B_CEILING:  rdata_nxt = ceiling_r[1];
            fcc_pkg::OFF_QUIET_STEP: rdata_nxt = quiet_r;
            default:                 rdata_nxt = 8'h00;
        endcase
    end

    // Register file flops
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            critical_temp_limit_span_r <= fcc_pkg::RST_SPAN;
            rl_span_r    <= fcc_pkg::RST_SPAN;
            critical_temp_limit_hyst_r <= fcc_pkg::RST_HYST;
            rl_hyst_r    <= fcc_pkg::RST_HYST;
            startup_r    <= '{fcc_pkg::RST_STARTUP, fcc_pkg::RST_STARTUP};
            floor_r      <= '{fcc_pkg::RST_FLOOR, fcc_pkg::RST_FLOOR};
            ceiling_r    <= '{fcc_pkg::RST_CEILING, fcc_pkg::RST_CEILING};
            quiet_r      <= fcc_pkg::RST_QUIET_STEP;
            rdata_r      <= 8'h00;
        end
        else
        begin
            critical_temp_limit_span_r <= critical_temp_limit_span_nxt;
            rl_span_r    <= rl_span_nxt;
            critical_temp_limit_hyst_r <= critical_temp_limit_hyst_nxt;
            rl_hyst_r    <= rl_hyst_nxt;
            startup_r    <= startup_nxt;
            floor_r      <= floor_nxt;
            ceiling_r    <= ceiling_nxt;
            quiet_r      <= quiet_nxt;
            rdata_r      <= rdata_nxt;
        end
    end

    assign REG_RDATA = rdata_r;

    // ==========================================================
    // Per-input temperature state
    // Index 0 thermistor a, 1 thermistor b, 2 remote, 3 local
    logic [7:0]  temp_in [4];
    logic [7:0]  on_in [4];
    logic [7:0]  crit_in [4];
    logic [3:0]  span_code [4];
    logic [3:0]  hyst [4];
    logic [3:0]  active_r, active_nxt;
    logic [3:0]  crit_r, crit_nxt;
    logic [12:0] frac [4];

    assign temp_in   = '{TEMP_TH_A, TEMP_TH_B, TEMP_REMOTE, TEMP_LOCAL};
    assign on_in     = '{ON_TEMP_TH_A, ON_TEMP_TH_B, ON_TEMP_REMOTE, ON_TEMP_LOCAL};
    assign crit_in   = '{CRIT_TH_A, CRIT_TH_B, CRIT_REMOTE, CRIT_LOCAL};
    assign span_code = '{critical_temp_limit_span_r[fcc_pkg::HI_NIB_LSB +: 4], critical_temp_limit_span_r[fcc_pkg::LO_NIB_LSB +: 4],
                         rl_span_r[fcc_pkg::HI_NIB_LSB +: 4], rl_span_r[fcc_pkg::LO_NIB_LSB +: 4]};
    assign hyst      = '{critical_temp_limit_hyst_r[fcc_pkg::HI_NIB_LSB +: 4], critical_temp_limit_hyst_r[fcc_pkg::LO_NIB_LSB +: 4],
                         rl_hyst_r[fcc_pkg::HI_NIB_LSB +: 4], rl_hyst_r[fcc_pkg::LO_NIB_LSB +: 4]};

    // Bring a code onto one offset scale so both formats compare alike
    function automatic logic [8:0] to_scale(input logic [7:0] code, input logic offset_fmt);
        logic [7:0] sat;
        sat = code;
        if (!offset_fmt && code > fcc_pkg::BIN_TEMP_MAX)
            sat = fcc_pkg::BIN_TEMP_MAX;
        to_scale = offset_fmt ? {1'b0, sat} : 9'({1'b0, sat} + fcc_pkg::TEMP_OFFSET);
    endfunction

    // Slope per span code in 1/4096 of full scale per degree
    function automatic logic [11:0] span_slope(input logic [3:0] code);
        case (code)
            4'h0:    span_slope = 12'h800;   // 2 degrees
            4'h1:    span_slope = 12'h666;   // 2.5
            4'h2:    span_slope = 12'h4cd;   // 3.33
            4'h3:    span_slope = 12'h400;   // 4
            4'h4:    span_slope = 12'h333;   // 5
            4'h5:    span_slope = 12'h266;   // 6.67
            4'h6:    span_slope = 12'h200;   // 8
            4'h7:    span_slope = 12'h19a;   // 10
            4'h8:    span_slope = 12'h133;   // 13.33
            4'h9:    span_slope = 12'h100;   // 16
            4'ha:    span_slope = 12'h0cd;   // 20
            4'hb:    span_slope = 12'h09a;   // 26.67
            4'hc:    span_slope = 12'h080;   // 32
            4'hd:    span_slope = 12'h066;   // 40
            4'he:    span_slope = 12'h04d;   // 53.33
            default: span_slope = 12'h033;   // 80
        endcase
    endfunction

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_input
            logic [8:0]  t_s, on_s, lim_s;
            logic [20:0] ramp;

            // Hysteresis latches for fan-on and critical states
            always_comb
            begin
                t_s   = to_scale(temp_in[gi], OFFSET_FORMAT);
                on_s  = to_scale(on_in[gi], OFFSET_FORMAT);
                lim_s = to_scale(crit_in[gi], OFFSET_FORMAT);
                active_nxt[gi] = active_r[gi];
                if (t_s > on_s)
                    active_nxt[gi] = 1'b1;
                else if (10'({1'b0, t_s} + hyst[gi]) < {1'b0, on_s})
                    active_nxt[gi] = 1'b0;
                crit_nxt[gi] = crit_r[gi];
                // A zero limit disables the critical override
                if (crit_in[gi] == 8'h00)
                    crit_nxt[gi] = 1'b0;
                else if (t_s > lim_s)
                    crit_nxt[gi] = 1'b1;
                else if (10'({1'b0, t_s} + hyst[gi]) < {1'b0, lim_s})
                    crit_nxt[gi] = 1'b0;
                // Ramp position, clipped at full once past the span
                ramp = (t_s > on_s) ? 21'(9'(t_s - on_s)) * 21'(span_slope(span_code[gi])) : 21'h0;
                frac[gi] = (ramp >= 21'(fcc_pkg::FRAC_FULL)) ? fcc_pkg::FRAC_FULL : ramp[12:0];
            end
        end
    endgenerate

    // Input state flops
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            active_r <= 4'h0;
            crit_r   <= 4'h0;
        end
        else
        begin
            active_r <= active_nxt;
            crit_r   <= crit_nxt;
        end
    end

    // Hottest demand wins for both fans
    logic [12:0] frac_max;
    always_comb
    begin
        frac_max = 13'h0000;
        for (int i = 0; i < 4; i++)
            if (active_r[i] && frac[i] > frac_max)
                frac_max = frac[i];
    end

    // ==========================================================
    // Quiet step interval and tach edges
    logic [15:0] tick_cnt_r, tick_cnt_nxt;
    logic        tick_r, tick_nxt;
    logic [1:0]  tach_d_r, tach_d_nxt;

    // Free-running divider; the interval sets the quiet ramp rate
    always_comb
    begin
        tick_nxt     = (tick_cnt_r == 16'(STEP_PERIOD_CYCLES - 1));
        tick_cnt_nxt = tick_nxt ? 16'h0000 : 16'(tick_cnt_r + 16'h0001);
        tach_d_nxt   = {FAN_B_TACH, FAN_A_TACH};
    end

    // Divider and tach history flops
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            tick_cnt_r <= 16'h0000;
            tick_r     <= 1'b0;
            tach_d_r   <= 2'h0;
        end
        else
        begin
            tick_cnt_r <= tick_cnt_nxt;
            tick_r     <= tick_nxt;
            tach_d_r   <= tach_d_nxt;
        end
    end

    // ==========================================================
    // Fan sequencers
    logic [1:0]  tach_now;
    logic [15:0] period [2];
    logic [7:0]  drive [2];
    logic [1:0]  quiet_en;
    logic [2:0]  quiet_code [2];

    assign tach_now   = {FAN_B_TACH, FAN_A_TACH};
    assign period     = '{FAN_A_PERIOD, FAN_B_PERIOD};
    assign quiet_en   = {quiet_r[fcc_pkg::QUIET_EN_B], quiet_r[fcc_pkg::QUIET_EN_A]};
    assign quiet_code = '{quiet_r[fcc_pkg::STEP_A_LSB +: 3], quiet_r[fcc_pkg::STEP_B_LSB +: 3]};

    genvar gf;
    generate
        for (gf = 0; gf < 2; gf++)
        begin : g_fan
            // Shorter period than the ceiling means the fan spins too fast
            logic too_fast;
            assign too_fast = AUTO_MODE && (period[gf] != 16'h0000) &&
                              (period[gf][15:8] < ceiling_r[gf]);

            fcc_fan_drive u_drive
            (
                .clk        (CLK),
                .rst        (RST),
                .want_on    (AUTO_MODE && (active_r != 4'h0)),
                .frac       (frac_max),
                .crit       (crit_r != 4'h0),
                .tach_pulse (tach_now[gf] && !tach_d_r[gf]),
                .too_fast   (too_fast),
                .tick       (tick_r),
                .startup    (startup_r[gf]),
                .floor_drv  (floor_r[gf]),
                .step_code  (quiet_code[gf]),
                .step_en    (quiet_en[gf]),
                .drive      (drive[gf])
            );
        end
    endgenerate

    // Drive outputs come straight from the sequencer flops
    assign FAN_A_DRIVE = drive[0];
    assign FAN_B_DRIVE = drive[1];

endmodule

// File: src/fcc_pkg.sv
// Shared constants for the fan curve configuration register bank
package fcc_pkg;

    // ==========================================================
    // Register offsets
    localparam logic [7:0] OFF_CRITICAL_TEMP_LIMIT_SPAN   = 8'h2c;
    localparam logic [7:0] OFF_RL_SPAN      = 8'h2d;
    localparam logic [7:0] OFF_CRITICAL_TEMP_LIMIT_HYST   = 8'h2e;
    localparam logic [7:0] OFF_RL_HYST      = 8'h2f;
    localparam logic [7:0] OFF_A_STARTUP    = 8'h30;
    localparam logic [7:0] OFF_B_STARTUP    = 8'h31;
    localparam logic [7:0] OFF_A_FLOOR      = 8'h32;
    localparam logic [7:0] OFF_B_FLOOR      = 8'h33;
    localparam logic [7:0] OFF_A_CEILING    = 8'h34;
    localparam logic [7:0] OFF_B_CEILING    = 8'h35;
    localparam logic [7:0] OFF_QUIET_STEP   = 8'h36;

    // ==========================================================
    // Values after reset
    localparam logic [7:0] RST_SPAN         = 8'hcc;
    localparam logic [7:0] RST_HYST         = 8'h44;
    localparam logic [7:0] RST_STARTUP      = 8'h80;
    localparam logic [7:0] RST_FLOOR        = 8'h60;
    localparam logic [7:0] RST_CEILING      = 8'h20;
    localparam logic [7:0] RST_QUIET_STEP   = 8'h3f;

    // ==========================================================
    // Field positions
    localparam int HI_NIB_LSB    = 4;    // Input a / remote field
    localparam int LO_NIB_LSB    = 0;    // Input b / local field
    localparam int STEP_A_LSB    = 0;
    localparam int STEP_B_LSB    = 3;
    localparam int QUIET_EN_A    = 6;
    localparam int QUIET_EN_B    = 7;

    // ==========================================================
    // Temperature codes
    localparam logic [8:0] TEMP_OFFSET     = 9'h040;  // Zero degrees in offset binary
    localparam logic [7:0] BIN_TEMP_MAX    = 8'h7f;   // Binary saturates at 127 degrees
    localparam logic [7:0] DRIVE_FULL      = 8'hff;
    localparam logic [7:0] DRIVE_OFF       = 8'h00;
    localparam logic [12:0] FRAC_FULL      = 13'h1000; // Unity in the 1/4096 ramp fraction
    localparam int FRAC_SHIFT              = 12;
    localparam logic [1:0] SPIN_TACH_COUNT = 2'h2;    // Tach periods at start-up drive

    // ==========================================================
    // Timing: drive step interval for the quiet ramp
    localparam int  CLK_HZ               = 25000000;
    localparam int  STEP_PERIOD_US       = 1000;
    localparam int  STEP_PERIOD_CYCLES   = (CLK_HZ / 1000000) * STEP_PERIOD_US;

    // Fan drive sequencer states
    typedef enum logic [1:0] {FD_OFF, FD_SPIN, FD_RUN} fcc_fan_state_t;

endpackage

// File: src/fcc_fan_drive.sv
// One fan's drive sequencer: start-up, floor, ceiling, quiet stepping
`timescale 1ns/100ps
module fcc_fan_drive
(
    input  wire logic        clk,        // System clock
    input  wire logic        rst,        // Async reset, active high
    input  wire logic        want_on,    // Some input is above its on temperature
    input  wire logic [12:0] frac,       // Ramp position, 0..4096
    input  wire logic        crit,       // Critical limit forcing full drive
    input  wire logic        tach_pulse, // One-cycle tach edge
    input  wire logic        too_fast,   // Fan above its speed ceiling
    input  wire logic        tick,       // Quiet step interval strobe
    input  wire logic [7:0]  startup,    // Start-up drive value
    input  wire logic [7:0]  floor_drv,  // Minimum running drive
    input  wire logic [2:0]  step_code,  // Quiet step code
    input  wire logic        step_en,    // Quiet stepping enabled
    output logic      [7:0]  drive       // Current drive value
);

    fcc_pkg::fcc_fan_state_t state_r, state_nxt;
    logic [7:0]  drive_r, drive_nxt;
    logic [1:0]  tach_cnt_r, tach_cnt_nxt;
    logic [7:0]  step;
    logic [7:0]  target;
    logic [20:0] prod;

    assign drive = drive_r;

    // ==========================================================
    // Step size decode
    always_comb
    begin
        case (step_code)
            3'h0:    step = 8'h01;
            3'h1:    step = 8'h02;
            3'h2:    step = 8'h03;
            3'h3:    step = 8'h05;
            3'h4:    step = 8'h08;
            3'h5:    step = 8'h0c;
            3'h6:    step = 8'h18;
            default: step = 8'h30;
        endcase
    end

    // ==========================================================
    // Target: linear from floor to full across the span
    always_comb
    begin
        // Widen both factors first so the product keeps all of its bits
        prod   = 21'(8'(fcc_pkg::DRIVE_FULL - floor_drv)) * 21'(frac);
        target = 8'(floor_drv + 8'(prod >> fcc_pkg::FRAC_SHIFT));
        // A fan already at its target still has to back off while too fast
        if (too_fast && target >= drive_r)
            target = (drive_r > floor_drv) ? 8'(drive_r - 8'h01) : floor_drv;
        if (crit)
            target = fcc_pkg::DRIVE_FULL;
    end

    // ==========================================================
    // Sequencer next state
    always_comb
    begin
        state_nxt    = state_r;
        drive_nxt    = drive_r;
        tach_cnt_nxt = tach_cnt_r;
        case (state_r)
            fcc_pkg::FD_OFF:
            begin
                drive_nxt    = fcc_pkg::DRIVE_OFF;
                tach_cnt_nxt = 2'h0;
                if (crit)
                begin
                    state_nxt = fcc_pkg::FD_RUN;
                    drive_nxt = fcc_pkg::DRIVE_FULL;
                end
                else if (want_on)
                begin
                    state_nxt = fcc_pkg::FD_SPIN;
                    drive_nxt = startup;
                end
            end
            fcc_pkg::FD_SPIN:
            begin
                drive_nxt = startup;
                if (tach_pulse)
                    tach_cnt_nxt = 2'(tach_cnt_r + 2'h1);
                if (crit)
                begin
                    state_nxt = fcc_pkg::FD_RUN;
                    drive_nxt = fcc_pkg::DRIVE_FULL;
                end
                else if (!want_on)
                    state_nxt = fcc_pkg::FD_OFF;
                else if (tach_pulse && 2'(tach_cnt_r + 2'h1) == fcc_pkg::SPIN_TACH_COUNT)
                begin
                    state_nxt = fcc_pkg::FD_RUN;
                    drive_nxt = floor_drv;
                end
            end
            fcc_pkg::FD_RUN:
            begin
                if (!want_on && !crit)
                begin
                    state_nxt = fcc_pkg::FD_OFF;
                    drive_nxt = fcc_pkg::DRIVE_OFF;
                end
                else if (crit || !step_en)
                    drive_nxt = target;
                else if (tick)
                begin
                    // Quiet mode: move at most one step per interval
                    if (target > drive_r)
                        drive_nxt = (8'(target - drive_r) > step) ? 8'(drive_r + step) : target;
                    else if (target < drive_r)
                        drive_nxt = (8'(drive_r - target) > step) ? 8'(drive_r - step) : target;
                end
            end
            default:
            begin
                state_nxt = fcc_pkg::FD_OFF;
                drive_nxt = fcc_pkg::DRIVE_OFF;
            end
        endcase
    end

    // Sequencer registers
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state_r    <= fcc_pkg::FD_OFF;
            drive_r    <= fcc_pkg::DRIVE_OFF;
            tach_cnt_r <= 2'h0;
        end
        else
        begin
            state_r    <= state_nxt;
            drive_r    <= drive_nxt;
            tach_cnt_r <= tach_cnt_nxt;
        end
    end

endmodule

// File: dv/fcc_regs_asserts.sv
// Port checker for the fan curve register bank
`timescale 1ns/100ps
module fcc_regs_asserts
(
    input wire logic       CLK,           // System clock
    input wire logic       RST,           // Async reset, active high
    input wire logic [7:0] REG_ADDR,      // Register offset
    input wire logic       REG_WR,        // Write strobe
    input wire logic [7:0] REG_WDATA,     // Write data
    input wire logic [7:0] REG_RDATA,     // Registered read data
    input wire logic       AUTO_MODE,     // Automatic control enable
    input wire logic       OFFSET_FORMAT, // Offset binary codes
    input wire logic [7:0] TEMP_LOCAL,    // Local reading
    input wire logic [7:0] CRIT_LOCAL,    // Local critical limit
    input wire logic [7:0] FAN_A_DRIVE,   // Fan a drive
    input wire logic [7:0] FAN_B_DRIVE    // Fan b drive
);
    logic mapped;
    // ==========
    // Decode kept apart so the properties stay short
    assign mapped = REG_ADDR inside {[8'h2c:8'h36]};
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    sequence hot_seq;
        OFFSET_FORMAT && CRIT_LOCAL != 8'h00 && TEMP_LOCAL > CRIT_LOCAL;
    endsequence
    property wr_rd_p;
        logic [7:0] a, d;
        (REG_WR && mapped, a = REG_ADDR, d = REG_WDATA) ##1 (REG_ADDR == a && !REG_WR) |=> REG_RDATA == d;
    endproperty
    AST_WR_RD: assert property (wr_rd_p) else $error("bad readback");
    AST_UNMAPPED: assert property (!mapped |=> REG_RDATA == 8'h00) else $error("unmapped not zero");
    // Read data still shows the reset zero on the first edge after release
    AST_RD_HOLD: assert property ((!REG_WR && $stable(REG_ADDR) && !$past(RST)) [*3]
        |-> $stable(REG_RDATA)) else $error("read data moved");
    // First clean edge after reset: the read mux sees the reset value
    AST_RST_VAL: assert property ($past(RST) && !RST && !REG_WR && REG_ADDR == 8'h36
        |=> REG_RDATA == 8'h3f) else $error("bad reset value");
    AST_CRIT_A: assert property (hot_seq [*2] |=> FAN_A_DRIVE == 8'hff) else $error("fan a not full");
    AST_CRIT_B: assert property (hot_seq [*2] |=> FAN_B_DRIVE == 8'hff) else $error("fan b not full");
    // The enable is sampled on the edge that loads the start-up drive
    AST_START_A: assert property ($rose(FAN_A_DRIVE != 8'h00)
        |-> $past(AUTO_MODE) || FAN_A_DRIVE == 8'hff) else $error("fan a started unasked");
    AST_START_B: assert property ($rose(FAN_B_DRIVE != 8'h00)
        |-> $past(AUTO_MODE) || FAN_B_DRIVE == 8'hff) else $error("fan b started unasked");
endmodule
bind fcc_regs fcc_regs_asserts u_asserts (.CLK(CLK), .RST(RST), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR),
    .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .AUTO_MODE(AUTO_MODE), .OFFSET_FORMAT(OFFSET_FORMAT),
    .TEMP_LOCAL(TEMP_LOCAL), .CRIT_LOCAL(CRIT_LOCAL), .FAN_A_DRIVE(FAN_A_DRIVE), .FAN_B_DRIVE(FAN_B_DRIVE));

// File: dv/fcc_regs_tb.sv
// Self-checking bench for the fan curve register bank
`timescale 1ns/100ps
module fcc_regs_tb;
    logic        clk = 1'b0, rst = 1'b1, wr = 1'b0, auto_m = 1'b0, ofs = 1'b0, tach = 1'b0;
    logic [7:0]  addr = 8'h36, wd = 8'h00, t = 8'h80, on_t = 8'h7f, crit = 8'h00, rd, drv_a, drv_b;
    logic [15:0] per = 16'hffff;
    int          mismatches = 0, checks_done = 0, cycles = 0;
    logic [7:0]  model [int]; // Expected register contents by offset
    // ==========
    // All inputs of a kind share one driver so every path sees traffic
    always #20 clk = ~clk;
    fcc_regs #(.STEP_PERIOD_CYCLES(8)) dut (.CLK(clk), .RST(rst), .REG_ADDR(addr), .REG_WR(wr), .REG_WDATA(wd),
        .REG_RDATA(rd), .AUTO_MODE(auto_m), .OFFSET_FORMAT(ofs), .TEMP_TH_A(t), .TEMP_TH_B(t), .TEMP_REMOTE(t),
        .TEMP_LOCAL(t), .ON_TEMP_TH_A(on_t), .ON_TEMP_TH_B(on_t), .ON_TEMP_REMOTE(on_t), .ON_TEMP_LOCAL(on_t),
        .CRIT_TH_A(crit), .CRIT_TH_B(crit), .CRIT_REMOTE(crit), .CRIT_LOCAL(crit), .FAN_A_TACH(tach),
        .FAN_B_TACH(tach), .FAN_A_PERIOD(per), .FAN_B_PERIOD(per), .FAN_A_DRIVE(drv_a), .FAN_B_DRIVE(drv_b));
    // Hang guard: the sequence needs under a thousand cycles
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            mismatches++;
            end_of_test();
        end
    end
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    function automatic logic [7:0] dv(input logic [7:0] a);
        return a < 8'h2c || a > 8'h36 ? 8'h00 : a < 8'h2e ? 8'hcc : a < 8'h30 ? 8'h44 :
            a < 8'h32 ? 8'h80 : a < 8'h34 ? 8'h60 : a < 8'h36 ? 8'h20 : 8'h3f;
    endfunction
    // Reads show the addressed register one edge after the address
    task automatic rd_reg(input logic [7:0] a);
        addr <= a;
        repeat (2) @(posedge clk);
        chk(rd, model[a]);
    endtask
    // Write, then read back; unmapped offsets leave the model alone
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        if (a inside {[8'h2c:8'h36]})
            model[a] = d;
        wd <= d;
        wr <= 1'b1;
        addr <= a;
        @(posedge clk);
        wr <= 1'b0;
        rd_reg(a);
    endtask
    task automatic pulse();
        tach <= 1'b1;
        repeat (2) @(posedge clk);
        tach <= 1'b0;
        repeat (3) @(posedge clk);
    endtask
    task automatic end_of_test();
        if (mismatches == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial
    begin
        void'($urandom(98));
        for (int a = 8'h2b; a < 8'h38; a++) model[a] = dv(a[7:0]);
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        // Keep the reset address one more edge so its reset value is read out
        @(posedge clk);
        for (int a = 8'h2b; a < 8'h38; a++) rd_reg(a[7:0]);
        for (int a = 8'h2b; a < 8'h38; a++) wr_reg(a[7:0], 8'($urandom));
        for (int a = 8'h2b; a < 8'h38; a++) wr_reg(a[7:0], dv(a[7:0]));
        auto_m <= 1'b1;
        repeat (6) @(posedge clk);
        chk(drv_a, 8'h00);
        ofs <= 1'b1;
        repeat (4) @(posedge clk);
        chk(drv_b, model[8'h31]);
        pulse();
        chk(drv_a, model[8'h30]);
        pulse();
        chk(8'(drv_a >= model[8'h32] && drv_a < 8'h6a), 8'h01);
        t <= 8'ha7;
        repeat (4) @(posedge clk);
        chk(drv_a, 8'hff);
        per <= 16'h0100;
        repeat (300) @(posedge clk);
        chk(drv_a, model[8'h32]);
        // Fan a quiet with step code 3 (5 per tick); four or five ticks fit the wait
        wr_reg(8'h36, 8'h43);
        per <= 16'hffff;
        repeat (40) @(posedge clk);
        chk(drv_b, 8'hff);
        chk(8'(drv_a == 8'h74 || drv_a == 8'h79), 8'h01);
        crit <= 8'ha0;
        repeat (4) @(posedge clk);
        t <= 8'h9e;
        repeat (4) @(posedge clk);
        chk(drv_a, 8'hff);
        t <= 8'h90;
        repeat (4) @(posedge clk);
        chk(8'(drv_b < 8'hff), 8'h01);
        auto_m <= 1'b0;
        crit <= 8'h00;
        repeat (4) @(posedge clk);
        chk(drv_a, 8'h00);
        end_of_test();
    end
endmodule
